// ---- common/eeprom_guard_pkg.sv ----
// constants of the serial eeprom write-protect and status block
// assumes a 100 MHz system clock that oversamples every serial pin
package eeprom_guard_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TWC_MS = 5;
    // longest self-timed cycle, rounded down to whole clocks
    localparam int TWC_CYCLES = (TWC_MS * 1000000) / CLK_PERIOD_NS;
    localparam int TWC_CNT_W = 24;

    // ----------------------------------------------------------------
    // instruction codes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_ARRAY_READ = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
    localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_READ_STATE = 8'h05;
    localparam logic [7:0] OP_WRITE_STATE = 8'h01;

    // ----------------------------------------------------------------
    // status word fields
    // ----------------------------------------------------------------
    localparam int SR_BUSY = 0;
    localparam int SR_LATCH = 1;
    localparam int SR_BP_LO = 2;
    localparam int SR_BP_HI = 3;
    localparam int SR_HW_EN = 7;
    // nonvolatile triple {hw_guard_enable, block_guard_hi, block_guard_lo}
    localparam logic [2:0] NV_RESET = 3'h0;

    // ----------------------------------------------------------------
    // array geometry and guarded ranges
    // ----------------------------------------------------------------
    localparam int ADDR_W = 11;
    localparam logic [10:0] QUARTER_BASE = 11'h600;
    localparam logic [10:0] HALF_BASE = 11'h400;
    localparam logic [10:0] ARRAY_TOP = 11'h7ff;
    localparam int ADDR_BYTES = 2;

endpackage

// ---- src/eeprom_pin_sync.sv ----
// two-flop synchroniser for the asynchronous serial pins
// assumes pins are slow against CLK; reset loads a fixed idle level
`timescale 1ns/10ps
module eeprom_pin_sync
#(
    parameter int W = 1,
    parameter logic [W-1:0] IDLE = '0
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [W-1:0] D,
    output logic [W-1:0] Q
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            meta_reg <= IDLE;
            Q <= IDLE;
        end
        else
        begin
            meta_reg <= D;
            Q <= meta_reg;
        end
    end

endmodule

// ---- src/eeprom_guard.sv ----
// serial eeprom write latch, status word, block and pin guarding
// assumes all serial pins are asynchronous and oversampled by CLK;
// array storage itself lives outside and is told of started writes
`timescale 1ns/10ps
module eeprom_guard
#(
    parameter int WRITE_CYCLES = eeprom_guard_pkg::TWC_CYCLES,
    parameter logic [2:0] NV_INIT = eeprom_guard_pkg::NV_RESET
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic SI,
    input wire logic HOLD_N,
    input wire logic WP_N,
    output logic SO_OUT,
    output logic SO_OE,
    output logic BUSY,
    output logic ARRAY_WR_START,
    output logic [eeprom_guard_pkg::ADDR_W-1:0] ARRAY_WR_ADDR
);

    typedef enum logic [3:0]
    {
        ST_IDLE,
        ST_CMD,
        ST_CMD_DONE,
        ST_ADDR,
        ST_DATA,
        ST_STAT_IN,
        ST_STAT_DONE,
        ST_STAT_OUT,
        ST_IGNORE
    } state_e;

    if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << eeprom_guard_pkg::TWC_CNT_W))
    begin : g_bad_cycles
        $error("WRITE_CYCLES out of counter range");
    end

    // ----------------------------------------------------------------
    // guarded address decode
    // ----------------------------------------------------------------
    function automatic logic guarded(input logic [1:0] bp,
                                     input logic [eeprom_guard_pkg::ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        unique case (bp)
            2'h0: hit = 1'b0;
            2'h1: hit = a >= eeprom_guard_pkg::QUARTER_BASE;
            2'h2: hit = a >= eeprom_guard_pkg::HALF_BASE;
            2'h3: hit = a <= eeprom_guard_pkg::ARRAY_TOP;
        endcase
        return hit;
    endfunction

    // ----------------------------------------------------------------
    // pin sampling and edge detection
    // ----------------------------------------------------------------
    logic [4:0] pins_s;
    logic cs_n_s, sck_s, si_s, hold_s, wp_n_s;
    logic sck_d_reg, cs_d_reg;
    logic sck_rise, sck_fall, cs_fall, cs_rise;

    eeprom_pin_sync #(.W(5), .IDLE(5'h17)) u_sync
    (
        .CLK(CLK),
        .RST(RST),
        .D({CS_N, SCK, SI, HOLD_N, WP_N}),
        .Q(pins_s)
    );

    assign {cs_n_s, sck_s, si_s, hold_s, wp_n_s} = pins_s;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            sck_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
        end
        else
        begin
            sck_d_reg <= sck_s;
            cs_d_reg <= cs_n_s;
        end
    end

    assign sck_rise = sck_s & ~sck_d_reg;
    assign sck_fall = ~sck_s & sck_d_reg;
    assign cs_fall = ~cs_n_s & cs_d_reg;
    assign cs_rise = cs_n_s & ~cs_d_reg;

    // ----------------------------------------------------------------
    // selection and pause
    // ----------------------------------------------------------------
    logic active_reg, paused_reg;
    logic clk_rise_ok, clk_fall_ok;

    always_ff @(posedge CLK)
    begin
        if (RST)
            active_reg <= 1'b0;
        else if (cs_rise)
            active_reg <= 1'b0;
        else if (cs_fall)
            active_reg <= 1'b1;
    end

    always_ff @(posedge CLK)
    begin
        if (RST || cs_n_s)
            paused_reg <= 1'b0;
        else if (!paused_reg)
        begin
            if (!hold_s && (!sck_s || sck_fall))
                paused_reg <= 1'b1;
        end
        else if (hold_s && !sck_s)
            paused_reg <= 1'b0;
    end

    // pending pause (pin low, clock still high) already blocks edges
    assign clk_rise_ok = sck_rise & active_reg & ~cs_n_s & hold_s & ~paused_reg;
    assign clk_fall_ok = sck_fall & active_reg & ~cs_n_s & hold_s & ~paused_reg;

    // ----------------------------------------------------------------
    // serial protocol
    // ----------------------------------------------------------------
    state_e state_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_in_reg;
    logic [7:0] rx_byte;
    logic addr_hi_done_reg, data_seen_reg, op_set_reg;
    logic [2:0] pend_reg;
    logic [eeprom_guard_pkg::ADDR_W-1:0] addr_reg;
    logic busy_reg;

    assign rx_byte = {shift_in_reg, si_s};

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 3'h0;
            shift_in_reg <= 7'h00;
            addr_hi_done_reg <= 1'b0;
            data_seen_reg <= 1'b0;
            op_set_reg <= 1'b0;
            pend_reg <= 3'h0;
            addr_reg <= '0;
        end
        else if (cs_fall)
        begin
            state_reg <= ST_CMD;
            bit_cnt_reg <= 3'h0;
            addr_hi_done_reg <= 1'b0;
            data_seen_reg <= 1'b0;
        end
        else if (cs_rise)
            state_reg <= ST_IDLE;
        else if (clk_rise_ok)
        begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_in_reg <= rx_byte[6:0];
            if (state_reg == ST_CMD_DONE || state_reg == ST_STAT_DONE)
                state_reg <= ST_IGNORE;
            else if (bit_cnt_reg == 3'h7)
            begin
                unique case (state_reg)
                    ST_CMD:
                    begin
                        if (rx_byte == eeprom_guard_pkg::OP_READ_STATE)
                            state_reg <= ST_STAT_OUT;
                        else if (busy_reg)
                            state_reg <= ST_IGNORE;
                        else if (rx_byte == eeprom_guard_pkg::OP_SET_LATCH ||
                                 rx_byte == eeprom_guard_pkg::OP_CLEAR_LATCH)
                        begin
                            state_reg <= ST_CMD_DONE;
                            op_set_reg <= rx_byte == eeprom_guard_pkg::OP_SET_LATCH;
                        end
                        else if (rx_byte == eeprom_guard_pkg::OP_WRITE_STATE)
                            state_reg <= ST_STAT_IN;
                        else if (rx_byte == eeprom_guard_pkg::OP_ARRAY_WRITE)
                            state_reg <= ST_ADDR;
                        else
                            state_reg <= ST_IGNORE;
                    end
                    ST_ADDR:
                    begin
                        addr_hi_done_reg <= 1'b1;
                        if (!addr_hi_done_reg)
                            addr_reg[10:8] <= rx_byte[2:0];
                        else
                        begin
                            addr_reg[7:0] <= rx_byte;
                            state_reg <= ST_DATA;
                        end
                    end
                    ST_DATA:
                        data_seen_reg <= 1'b1;
                    ST_STAT_IN:
                    begin
                        pend_reg <= {rx_byte[eeprom_guard_pkg::SR_HW_EN],
                                     rx_byte[eeprom_guard_pkg::SR_BP_HI],
                                     rx_byte[eeprom_guard_pkg::SR_BP_LO]};
                        state_reg <= ST_STAT_DONE;
                    end
                    default:
                        state_reg <= state_reg;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // guarding, write cycle and latch
    // ----------------------------------------------------------------
    logic [2:0] nv_reg;
    logic latch_reg, kind_stat_reg;
    logic [eeprom_guard_pkg::TWC_CNT_W-1:0] cyc_cnt_reg;
    logic hw_guard, start_stat, start_arr, wr_done;
    logic [7:0] status_word;

    assign hw_guard = ~wp_n_s & nv_reg[2];
    assign start_stat = cs_rise & (state_reg == ST_STAT_DONE) & latch_reg & ~hw_guard;
    assign start_arr = cs_rise & (state_reg == ST_DATA) & data_seen_reg &
                       (bit_cnt_reg == 3'h0) & latch_reg &
                       ~guarded(nv_reg[1:0], addr_reg);
    assign wr_done = busy_reg & (cyc_cnt_reg == '0);

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            busy_reg <= 1'b0;
            kind_stat_reg <= 1'b0;
            cyc_cnt_reg <= '0;
        end
        else if (start_stat || start_arr)
        begin
            busy_reg <= 1'b1;
            kind_stat_reg <= start_stat;
            cyc_cnt_reg <= eeprom_guard_pkg::TWC_CNT_W'(WRITE_CYCLES - 1);
        end
        else if (wr_done)
            busy_reg <= 1'b0;
        else if (busy_reg)
            cyc_cnt_reg <= cyc_cnt_reg - 1'b1;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            nv_reg <= NV_INIT;
        else if (wr_done && kind_stat_reg)
            nv_reg <= pend_reg;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            latch_reg <= 1'b0;
        else if (wr_done)
            latch_reg <= 1'b0;
        else if (cs_rise && state_reg == ST_CMD_DONE)
            latch_reg <= op_set_reg;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ARRAY_WR_START <= 1'b0;
            ARRAY_WR_ADDR <= '0;
        end
        else
        begin
            ARRAY_WR_START <= start_arr;
            if (start_arr)
                ARRAY_WR_ADDR <= addr_reg;
        end
    end

    assign BUSY = busy_reg;
    assign status_word = {nv_reg[2], 3'h0, nv_reg[1], nv_reg[0], latch_reg, busy_reg};

    // ----------------------------------------------------------------
    // serial output
    // ----------------------------------------------------------------
    logic [6:0] shift_out_reg;
    logic [2:0] out_cnt_reg;
    logic out_en_reg;

    always_ff @(posedge CLK)
    begin
        if (RST || cs_n_s)
        begin
            SO_OUT <= 1'b0;
            shift_out_reg <= 7'h00;
            out_cnt_reg <= 3'h0;
            out_en_reg <= 1'b0;
        end
        else if (clk_fall_ok && state_reg == ST_STAT_OUT)
        begin
            out_en_reg <= 1'b1;
            out_cnt_reg <= out_cnt_reg + 3'h1;
            if (out_cnt_reg == 3'h0)
            begin
                SO_OUT <= status_word[7];
                shift_out_reg <= status_word[6:0];
            end
            else
            begin
                SO_OUT <= shift_out_reg[6];
                shift_out_reg <= {shift_out_reg[5:0], 1'b0};
            end
        end
    end

    assign SO_OE = out_en_reg & ~cs_n_s & hold_s & ~paused_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    a_latch_set_cmd: assert property (
        cs_rise && state_reg == ST_CMD_DONE && op_set_reg && !busy_reg |=> latch_reg)
        else $error("latch not set after set command");
    a_latch_clr_cmd: assert property (
        cs_rise && state_reg == ST_CMD_DONE && !op_set_reg |=> !latch_reg)
        else $error("latch not cleared after clear command");
    a_latch_end_cycle: assert property (
        $fell(busy_reg) |-> !latch_reg)
        else $error("latch still set after write cycle");
    a_busy_holds: assert property (
        $rose(busy_reg) |-> busy_reg [*8])
        else $error("busy bit dropped early");
    a_start_needs_latch: assert property (
        $rose(busy_reg) |-> $past(latch_reg) && $past(cs_rise))
        else $error("write cycle started without latch or select rise");
    a_so_desel_float: assert property (
        cs_n_s |-> !SO_OE ##1 !out_en_reg)
        else $error("output driven while deselected");
    a_so_pause_float: assert property (
        !hold_s |-> !SO_OE)
        else $error("output driven while pause pin low");
    a_guard_refuse: assert property (
        cs_rise && state_reg == ST_STAT_DONE && hw_guard |=> !busy_reg ##1 $stable(nv_reg))
        else $error("guarded status write accepted");
    a_block_refuse: assert property (
        cs_rise && state_reg == ST_DATA && guarded(nv_reg[1:0], addr_reg) |=> !busy_reg)
        else $error("write to guarded block started");
    a_pause_freeze: assert property (
        paused_reg && !cs_n_s |=> $stable(bit_cnt_reg))
        else $error("serial state moved while paused");
    a_nv_only_stwr: assert property (
        !$stable(nv_reg) |-> $past(wr_done) && $past(kind_stat_reg))
        else $error("guard bits changed outside status write");

    c_status_write: cover property (start_stat);
    c_array_write: cover property (start_arr);
    c_pause_resume: cover property ($fell(paused_reg) && !cs_n_s);
    c_status_read_busy: cover property (SO_OE && busy_reg);

endmodule

// ---- testbench/spi_host_model.sv ----
// host side of the serial link: select, clock, data in and pause
// assumes the bench calls its tasks; clk is the system clock
`timescale 1ns/10ps
module spi_host_model
(
    input wire logic clk,
    input wire logic so_line,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n
);
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b1;
        hold_n = 1'b1;
    end

    // ------------------------------------------------------------
    // link tasks, 160 ns clock, changes at falling clk
    // ------------------------------------------------------------
    task automatic half();
        repeat (8) @(negedge clk);
    endtask

    task automatic sel();
        @(negedge clk);
        cs_n = 1'b0;
        half();
    endtask

    // released data line shows the inverse of its last bit
    task automatic desel();
        half();
        cs_n = 1'b1;
        si = ~si;
        half();
    endtask

    // n bits of tx, msb first; rx takes the output at each rising clock
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            si = tx[i];
            half();
            sck = 1'b1;
            rx[i] = so_line;
            half();
            sck = 1'b0;
        end
    endtask

    // pause and resume only while the clock is low, still selected
    task automatic pause(input logic on);
        half();
        hold_n = ~on;
        si = ~si;
        half();
    endtask
endmodule

// ---- testbench/eeprom_guard_bench.sv ----
// self-checking bench of the eeprom write latch, status word and guards
// assumes spi_host_model drives the serial pins; short write cycle
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module eeprom_guard_bench;
    localparam int WCYC = 1000;
    logic clk, rst, wp_n, so_out, so_oe, busy, wr_start;
    wire logic cs_n, sck, si, hold_n, so_line;
    logic [eeprom_guard_pkg::ADDR_W-1:0] wr_addr, last_addr;
    logic [7:0] rx, v;
    int fail_count, checks_done, n;
    int starts = 0;
    logic [7:0] bpv [2] = '{8'h04, 8'h08};
    logic [10:0] okad [2] = '{11'h5ff, 11'h3ff};

    logic so_last = 1'b0;

    // a released output line drifts to the inverse of its last driven bit
    always @(posedge clk)
    begin
        if (so_oe === 1'b1)
            so_last <= so_out;
    end

    assign so_line = so_oe ? so_out : ~so_last;

    eeprom_guard #(.WRITE_CYCLES(WCYC)) i_eeprom_guard (.CLK(clk), .RST(rst), .CS_N(cs_n),
        .SCK(sck), .SI(si), .HOLD_N(hold_n), .WP_N(wp_n), .SO_OUT(so_out), .SO_OE(so_oe),
        .BUSY(busy), .ARRAY_WR_START(wr_start), .ARRAY_WR_ADDR(wr_addr));
    spi_host_model i_spi_host_model (.clk(clk), .so_line(so_line), .cs_n(cs_n), .sck(sck),
        .si(si), .hold_n(hold_n));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (wr_start === 1'b1)
        begin
            starts <= starts + 1;
            last_addr <= wr_addr;
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic frame(input logic [31:0] w, input int nbits);
        int k;
        i_spi_host_model.sel();
        for (k = 0; k * 8 < nbits; k++)
            i_spi_host_model.xfer(w[31 - 8 * k -: 8], (nbits - 8 * k > 8) ? 8 : nbits - 8 * k, rx);
        i_spi_host_model.desel();
    endtask

    task automatic state_rd(output logic [7:0] s);
        i_spi_host_model.sel();
        i_spi_host_model.xfer(8'h05, 8, rx);
        i_spi_host_model.xfer(8'h00, 8, s);
        i_spi_host_model.desel();
    endtask

    task automatic idle();
        int t;
        for (t = 0; t < 2 * WCYC && busy !== 1'b0; t++)
            @(negedge clk);
    endtask

    task automatic state_wr(input logic [7:0] d);
        frame({8'h06, 24'h0}, 8);
        frame({8'h01, d, 16'h0}, 16);
        idle();
    endtask

    // array write with latch set; cnt is the number of starts seen
    task automatic arr_wr(input logic [10:0] a, input int nbits, output int cnt);
        int s0;
        frame({8'h06, 24'h0}, 8);
        s0 = starts;
        frame({8'h02, 5'h00, a, 8'h5a}, nbits);
        idle();
        cnt = starts - s0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        `CHK("so_oe", 1'b0, so_oe)
        `CHK("busy", 1'b0, busy)
        state_rd(v);
        `CHK("state", 8'h00, v)
        `CHK("so_oe idle", 1'b0, so_oe)
        $display("done: reset");
    endtask

    task automatic t_latch();
        frame({8'h06, 24'h0}, 8);
        state_rd(v);
        `CHK("latch set", 8'h02, v)
        frame({8'h04, 24'h0}, 8);
        state_rd(v);
        `CHK("latch clear", 8'h00, v)
        frame({8'h06, 8'h02, 16'h0}, 16);
        state_rd(v);
        `CHK("latch no rise", 8'h00, v)
        $display("done: latch");
    endtask

    task automatic t_state_write();
        int s0;
        frame({8'h06, 24'h0}, 8);
        frame({8'h01, 8'hff, 16'h0}, 16);
        `CHK("busy start", 1'b1, busy)
        state_rd(v);
        `CHK("state busy", 8'h03, v)
        s0 = starts;
        frame({8'h02, 5'h00, 11'h010, 8'h5a}, 32);
        `CHK("start busy", s0, starts)
        `CHK("busy held", 1'b1, busy)
        idle();
        `CHK("busy end", 1'b0, busy)
        state_rd(v);
        `CHK("state nv", 8'h8c, v)
        $display("done: state write");
    endtask

    task automatic t_guard();
        @(negedge clk) wp_n = 1'b0;
        frame({8'h06, 24'h0}, 8);
        frame({8'h01, 8'h00, 16'h0}, 16);
        `CHK("busy guarded", 1'b0, busy)
        state_rd(v);
        `CHK("state guarded", 8'h8e, v)
        arr_wr(11'h000, 32, n);
        `CHK("start all prot", 0, n)
        frame({8'h04, 24'h0}, 8);
        state_rd(v);
        `CHK("clear guarded", 8'h8c, v)
        @(negedge clk) wp_n = 1'b1;
        state_wr(8'h04);
        @(negedge clk) wp_n = 1'b0;
        $display("done: guard");
    endtask

    task automatic t_blocks();
        for (int i = 0; i < 2; i++)
        begin
            state_wr(bpv[i]);
            state_rd(v);
            `CHK("state blocks", bpv[i], v)
            arr_wr(okad[i], 32, n);
            `CHK("start free", 1, n)
            `CHK("start addr", okad[i], last_addr)
            state_rd(v);
            `CHK("latch after", bpv[i], v)
            arr_wr(okad[i] + 11'h001, 32, n);
            `CHK("start prot", 0, n)
            state_rd(v);
            `CHK("latch kept", bpv[i] | 8'h02, v)
        end
        arr_wr(11'h000, 29, n);
        `CHK("start partial", 0, n)
        $display("done: blocks");
    endtask

    task automatic t_pause();
        logic [7:0] a, b;
        i_spi_host_model.sel();
        i_spi_host_model.xfer(8'h05, 8, rx);
        i_spi_host_model.xfer(8'h00, 4, a);
        i_spi_host_model.pause(1'b1);
        `CHK("so_oe paused", 1'b0, so_oe)
        i_spi_host_model.pause(1'b0);
        i_spi_host_model.xfer(8'h00, 4, b);
        i_spi_host_model.desel();
        `CHK("state resumed", 8'h0a, {a[7:4], b[7:4]})
        `CHK("so_oe desel", 1'b0, so_oe)
        $display("done: pause");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        fail_count++;
        results();
    end

    initial
    begin
        rst = 1'b1;
        wp_n = 1'b1;
        fail_count = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        t_reset();
        t_latch();
        t_state_write();
        t_guard();
        t_blocks();
        t_pause();
        results();
    end
endmodule
